// >>> pkg/adc_cfg_pkg.sv
// constants shared by both ends of the converter configuration link
package adc_cfg_pkg;
   localparam int WORD_BITS     = 16;
   localparam int ADDR_BITS     = 7;
   localparam int DATA_BITS     = 8;
   localparam int SAMPLE_BITS   = 12;
   localparam int RW_POS        = 15;
   localparam int ADDR_MSB      = 14;
   localparam int ADDR_LSB      = 8;
   localparam logic [4:0] BIT_CNT_LAST  = 5'h0F;
   localparam logic [4:0] BIT_CNT_DONE  = 5'h10;
   localparam logic [4:0] BIT_CNT_ADDR  = 5'h07;
   localparam logic [4:0] BIT_CNT_RDBEG = 5'h08;
   // link register map
   localparam logic [6:0] SOFT_RESET_CONTROL_ADDR       = 7'h00;
   localparam logic [6:0] POWER_AND_FORMAT_CONTROL_ADDR = 7'h01;
   localparam logic [6:0] OUTPUT_MODE_CONTROL_ADDR      = 7'h02;
   localparam int SOFT_RESET_POS   = 7;
   localparam int DUTY_STAB_POS    = 7;
   localparam int SCRAMBLE_POS     = 6;
   localparam int SIGNED_POS       = 5;
   localparam int SLEEP_POS        = 4;
   localparam int NAP2_POS         = 3;
   localparam int NAP1_POS         = 0;
   localparam logic [7:0] POWER_FORMAT_MASK = 8'hF9;
   localparam logic [7:0] REG_RESET_VALUE   = 8'h00;
   localparam logic [15:0] SOFT_RESET_WORD  = 16'h0080;
   // host timing: pclk 50 ns, link clock half period in ns
   localparam int PCLK_NS           = 50;
   localparam int SCK_HALF_NS       = 200;
   localparam int SCK_HALF_CYCLES   = (SCK_HALF_NS + PCLK_NS - 1) / PCLK_NS;
   localparam logic [3:0] SCK_HALF_LAST = 4'(SCK_HALF_CYCLES - 1);
   localparam int NAP_RECOVER_SAMPLES = 100;
   // host apb register map, byte addresses
   localparam logic [7:0] HOST_CMD_ADDR    = 8'h00;
   localparam logic [7:0] HOST_STATUS_ADDR = 8'h04;
   localparam logic [7:0] HOST_RDATA_ADDR  = 8'h08;
   localparam int STATUS_BUSY_POS  = 0;
   localparam int STATUS_RESET_POS = 1;
endpackage

// >>> pkg/cfg_link_if.sv
// serial configuration link between host controller and converter
`timescale 1ns/1ps
interface cfg_link_if;
   logic cs_n;
   logic sck;
   logic sdi;
   logic sdo_out;
   logic sdo_oe;
   logic sdo;
   // open drain with external pull-up: low only while pulled
   assign sdo = (sdo_oe && !sdo_out) ? 1'b0 : 1'b1;
   modport device (input cs_n, input sck, input sdi, input sdo,
                   output sdo_out, output sdo_oe);
   modport host   (output cs_n, output sck, output sdi, input sdo);
endinterface

// >>> rtl/adc_cfg_device.sv
// converter end: serial mode registers and output formatting
`timescale 1ns/1ps
module adc_cfg_device
   import adc_cfg_pkg::*;
(
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   cfg_link_if.device                  link,
   input  wire logic                   interface_select,
   input  wire logic [SAMPLE_BITS-1:0] sample_in,
   output logic [SAMPLE_BITS-1:0]      sample_out,
   output logic                        duty_stabilizer_disable,
   output logic                        output_scramble_enable,
   output logic                        signed_format_select,
   output logic                        sleep_enable,
   output logic [1:0]                  channel_power_down,
   output logic [DATA_BITS-1:0]        output_mode
);
   // pin synchronisers: bit 0 cs_n, 1 sck, 2 sdi, 3 select
   logic [3:0]           sync1_r;
   logic [3:0]           sync2_r;
   logic [3:0]           prev_r;
   logic [4:0]           bit_cnt_r;
   logic [WORD_BITS-2:0] rx_r;
   logic                 rd_mode_r;
   logic [DATA_BITS-1:0] rd_shift_r;
   logic                 sdo_oe_r;
   logic [DATA_BITS-1:0] pf_r;
   logic [DATA_BITS-1:0] om_r;
   logic [SAMPLE_BITS-1:0] sample_r;
   logic [1:0]           cpd_r;

   wire serial_on  = !sync2_r[3];
   wire cs_fall    = prev_r[0] && !sync2_r[0];
   wire cs_low     = !sync2_r[0];
   wire sck_rise   = !prev_r[1] && sync2_r[1];
   wire sck_fall   = prev_r[1] && !sync2_r[1];
   wire sdi_s      = sync2_r[2];
   wire take_bit   = serial_on && cs_low && !cs_fall && sck_rise
                     && (bit_cnt_r < BIT_CNT_DONE);
   wire [WORD_BITS-1:0] word_w = {rx_r, sdi_s};
   wire word_done  = take_bit && (bit_cnt_r == BIT_CNT_LAST);
   wire [ADDR_BITS-1:0] wr_addr = word_w[ADDR_MSB:ADDR_LSB];
   wire [DATA_BITS-1:0] wr_data = word_w[DATA_BITS-1:0];
   wire do_write   = word_done && !word_w[RW_POS];
   wire soft_reset = do_write && (wr_addr == SOFT_RESET_CONTROL_ADDR)
                     && wr_data[SOFT_RESET_POS];
   wire wr_pf      = do_write && (wr_addr == POWER_AND_FORMAT_CONTROL_ADDR);
   wire wr_om      = do_write && (wr_addr == OUTPUT_MODE_CONTROL_ADDR);
   // address is complete after the eighth rise: rw then a6..a0
   wire addr_done  = take_bit && (bit_cnt_r == BIT_CNT_ADDR);
   wire [ADDR_BITS-1:0] rd_addr = {rx_r[ADDR_BITS-2:0], sdi_s};
   wire rd_flag    = rx_r[ADDR_BITS-1];
   wire drive_bit  = rd_mode_r && cs_low && sck_fall && serial_on
                     && (bit_cnt_r >= BIT_CNT_RDBEG) && (bit_cnt_r < BIT_CNT_DONE);

   // readable contents; reset register reads back zero
   function automatic logic [DATA_BITS-1:0] reg_value(input logic [ADDR_BITS-1:0] a);
      if (a == POWER_AND_FORMAT_CONTROL_ADDR)
         reg_value = pf_r;
      else if (a == OUTPUT_MODE_CONTROL_ADDR)
         reg_value = om_r;
      else
         reg_value = REG_RESET_VALUE;
   endfunction

   // formatting: signed flips msb, scrambling xors lsb upward
   wire [SAMPLE_BITS-1:0] fmt_signed = pf_r[SIGNED_POS]
        ? {~sample_in[SAMPLE_BITS-1], sample_in[SAMPLE_BITS-2:0]}
        : sample_in;
   wire [SAMPLE_BITS-1:0] fmt_scram = pf_r[SCRAMBLE_POS]
        ? {fmt_signed[SAMPLE_BITS-1:1] ^ {(SAMPLE_BITS-1){fmt_signed[0]}}, fmt_signed[0]}
        : fmt_signed;
   // channel power-down: sleep overrides each nap bit
   wire [1:0] cpd_w = {pf_r[SLEEP_POS] | pf_r[NAP2_POS], pf_r[SLEEP_POS] | pf_r[NAP1_POS]};

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         // idle pin levels, so no false clock edge after reset
         sync1_r <= 4'h9;
         sync2_r <= 4'h9;
         prev_r  <= 4'h9;
      end
      else
      begin
         sync1_r <= {interface_select, link.sdi, link.sck, link.cs_n};
         sync2_r <= sync1_r;
         prev_r  <= sync2_r;
      end
   end

   // word capture
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         bit_cnt_r <= 5'h00;
         rx_r      <= '0;
         rd_mode_r <= 1'b0;
      end
      else if (cs_fall || !cs_low)
      begin
         bit_cnt_r <= 5'h00;
         rd_mode_r <= 1'b0;
      end
      else if (take_bit)
      begin
         bit_cnt_r <= bit_cnt_r + 5'h01;
         rx_r      <= word_w[WORD_BITS-2:0];
         if (addr_done)
            rd_mode_r <= rd_flag;
      end
   end

   // mode registers; undefined bits and addresses dropped
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pf_r <= REG_RESET_VALUE;
         om_r <= REG_RESET_VALUE;
      end
      else if (soft_reset)
      begin
         pf_r <= REG_RESET_VALUE;
         om_r <= REG_RESET_VALUE;
      end
      else
      begin
         if (wr_pf)
            pf_r <= wr_data & POWER_FORMAT_MASK;
         if (wr_om)
            om_r <= wr_data;
      end
   end

   // read-back: data on the eight falls after the address
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rd_shift_r <= '0;
         sdo_oe_r   <= 1'b0;
      end
      else if (addr_done)
         rd_shift_r <= reg_value(rd_addr);
      else if (drive_bit)
      begin
         sdo_oe_r   <= !rd_shift_r[DATA_BITS-1];
         rd_shift_r <= {rd_shift_r[DATA_BITS-2:0], 1'b0};
      end
      else if (!cs_low || (sck_fall && bit_cnt_r == BIT_CNT_DONE) || !serial_on)
         sdo_oe_r   <= 1'b0;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sample_r <= '0;
         cpd_r    <= 2'h0;
      end
      else
      begin
         sample_r <= fmt_scram;
         cpd_r    <= cpd_w;
      end
   end

   assign link.sdo_out            = 1'b0;
   assign link.sdo_oe             = sdo_oe_r;
   assign sample_out              = sample_r;
   assign duty_stabilizer_disable = pf_r[DUTY_STAB_POS];
   assign output_scramble_enable  = pf_r[SCRAMBLE_POS];
   assign signed_format_select    = pf_r[SIGNED_POS];
   assign sleep_enable            = pf_r[SLEEP_POS];
   assign channel_power_down      = cpd_r;
   assign output_mode             = om_r;
endmodule

// >>> rtl/adc_cfg_host.sv
// host end: apb-driven serial master for the configuration link
`timescale 1ns/1ps
module adc_cfg_host
   import adc_cfg_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   cfg_link_if.host         link
);
   typedef enum logic [2:0] {H_IDLE, H_LEAD, H_LOW, H_HIGH, H_TRAIL, H_GAP} host_state_type;

   host_state_type       state_r;
   logic [3:0]           div_r;
   logic [3:0]           bits_r;
   logic [WORD_BITS-1:0] tx_r;
   logic [WORD_BITS-1:0] rx_r;
   logic                 reset_sent_r;
   logic                 cs_n_r;
   logic                 sck_r;
   logic                 sdi_r;
   logic                 sdo_s1_r;
   logic                 sdo_s2_r;
   logic [31:0]          prdata_r;
   logic                 pready_r;

   wire tick     = (div_r == SCK_HALF_LAST);
   wire busy     = (state_r != H_IDLE);
   wire apb_done = psel && penable && pready_r;
   wire cmd_wr   = apb_done && pwrite && (paddr == HOST_CMD_ADDR) && !busy && reset_sent_r;
   wire auto_rst = !reset_sent_r && !busy;
   wire start    = cmd_wr || auto_rst;
   wire [WORD_BITS-1:0] start_word = auto_rst ? SOFT_RESET_WORD : pwdata[WORD_BITS-1:0];
   wire [31:0] status_w = {30'h0, reset_sent_r, busy};
   wire [31:0] rd_mux = (paddr == HOST_STATUS_ADDR) ? status_w
                      : (paddr == HOST_RDATA_ADDR)  ? {16'h0, rx_r}
                      : 32'h0;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sdo_s1_r <= 1'b1;
         sdo_s2_r <= 1'b1;
      end
      else
      begin
         sdo_s1_r <= link.sdo;
         sdo_s2_r <= sdo_s1_r;
      end
   end

   // apb slave: pready in the second access cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_r <= 1'b0;
         prdata_r <= 32'h0;
      end
      else
      begin
         pready_r <= psel && penable && !pready_r;
         if (psel && penable && !pready_r && !pwrite)
            prdata_r <= rd_mux;
      end
   end

   // serial master: sixteen bits msb first, sampled late in high phase
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_r      <= H_IDLE;
         div_r        <= 4'h0;
         bits_r       <= 4'h0;
         tx_r         <= '0;
         rx_r         <= '0;
         reset_sent_r <= 1'b0;
         cs_n_r       <= 1'b1;
         sck_r        <= 1'b0;
         sdi_r        <= 1'b0;
      end
      else
      begin
         div_r <= (tick || !busy) ? 4'h0 : div_r + 4'h1;
         case (state_r)
            H_IDLE:
               if (start)
               begin
                  state_r      <= H_LEAD;
                  cs_n_r       <= 1'b0;
                  tx_r         <= start_word;
                  sdi_r        <= start_word[RW_POS];
                  bits_r       <= 4'h0;
                  reset_sent_r <= 1'b1;
               end
            H_LEAD:
               if (tick)
               begin
                  state_r <= H_HIGH;
                  sck_r   <= 1'b1;
               end
            H_LOW:
               if (tick)
               begin
                  state_r <= H_HIGH;
                  sck_r   <= 1'b1;
               end
            H_HIGH:
               if (tick)
               begin
                  sck_r  <= 1'b0;
                  rx_r   <= {rx_r[WORD_BITS-2:0], sdo_s2_r};
                  tx_r   <= {tx_r[WORD_BITS-2:0], 1'b0};
                  sdi_r  <= tx_r[WORD_BITS-2];
                  bits_r <= bits_r + 4'h1;
                  state_r <= (bits_r == BIT_CNT_LAST[3:0]) ? H_TRAIL : H_LOW;
               end
            H_TRAIL:
               if (tick)
               begin
                  state_r <= H_GAP;
                  cs_n_r  <= 1'b1;
               end
            H_GAP:
               if (tick)
                  state_r <= H_IDLE;
            default:
               state_r <= H_IDLE;
         endcase
      end
   end

   assign prdata    = prdata_r;
   assign pready    = pready_r;
   assign pslverr   = 1'b0;
   assign link.cs_n = cs_n_r;
   assign link.sck  = sck_r;
   assign link.sdi  = sdi_r;
endmodule

// >>> verif/adc_cfg_assertions.sv
// wire-level checks on the configuration link
`timescale 1ns/1ps
module adc_cfg_assertions (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic cs_n,
   input wire logic sck,
   input wire logic sdi,
   input wire logic sdo_out,
   input wire logic sdo_oe,
   input wire logic sdo
);
   logic       sck_q_r;
   logic       cs_q_r;
   logic       rd_r;
   logic [4:0] rises_r;
   logic [4:0] falls_r;
   wire        sck_rise = sck && !sck_q_r;
   wire        sck_fall = !sck && sck_q_r;
   wire        cs_fall  = !cs_n && cs_q_r;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sck_q_r <= 1'b0;
         cs_q_r  <= 1'b1;
      end
      else
      begin
         sck_q_r <= sck;
         cs_q_r  <= cs_n;
      end
   end
   // rises per frame, falls per frame, flag from first bit
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         rises_r <= 5'h00;
      else if (cs_n)
         rises_r <= 5'h00;
      else if (sck_rise)
         rises_r <= rises_r + 5'h01;
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         falls_r <= 5'h00;
      else if (cs_fall)
         falls_r <= 5'h00;
      else if (sck_fall)
         falls_r <= falls_r + 5'h01;
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         rd_r <= 1'b0;
      else if (sck_rise && rises_r == 5'h00)
         rd_r <= sdi;
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_open_drain: assert property (!sdo_out)
      else $error("data out driven high");
   chk_word_length: assert property ($rose(cs_n) |-> rises_r == 5'h10)
      else $error("frame without sixteen clock rises");
   chk_rise_framed: assert property (sck_rise |-> !cs_n)
      else $error("clock rise outside frame");
   chk_start_gap: assert property ($fell(cs_n) |-> !sck [*3])
      else $error("clock rose too soon after select");
   chk_idle_gap: assert property ($rose(cs_n) |-> cs_n [*4])
      else $error("select gap too short");
   chk_sck_idle: assert property (cs_n |-> !sck)
      else $error("clock high while idle");
   chk_sdi_hold: assert property (sck && $past(sck) |-> $stable(sdi))
      else $error("data in moved while clock high");
   chk_sdo_read_only: assert property (sdo_oe |-> rd_r && falls_r >= 5'h08)
      else $error("data out pulled outside read bits");
   chk_sdo_release: assert property (cs_n [*8] |-> !sdo_oe)
      else $error("data out not released");
   cov_read_bit: cover property (sdo_oe && !sdo);
   cov_read_frame: cover property ($rose(cs_n) && rd_r);
   cov_write_frame: cover property ($rose(cs_n) && !rd_r);
endmodule

// >>> verif/tb.sv
// self-checking bench: apb host end facing the converter end
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_compared++; if ((e) !== (s)) begin failures++; \
   $display("wrong value %s exp %h got %h", n, e, s); end end
module tb;
   import adc_cfg_pkg::*;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        interface_select = 1'b0;
   logic [11:0] sample_in = 12'h000;
   logic [11:0] sample_out;
   logic        dsd, ose, sfs, slp;
   logic [1:0]  cpd;
   logic [7:0]  omo, pf, om, d, e;
   logic [31:0] q;
   logic [15:0] mon;
   logic        sck_q = 1'b0;
   int          failures = 0;
   int          n_compared = 0;
   int          i;
   always #25 pclk = ~pclk;
   cfg_link_if link_if();
   adc_cfg_host adc_cfg_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link_if));
   adc_cfg_device adc_cfg_device_inst (.pclk(pclk), .presetn(presetn), .link(link_if),
      .interface_select(interface_select), .sample_in(sample_in),
      .sample_out(sample_out), .duty_stabilizer_disable(dsd),
      .output_scramble_enable(ose), .signed_format_select(sfs), .sleep_enable(slp),
      .channel_power_down(cpd), .output_mode(omo));
   adc_cfg_assertions adc_cfg_assertions_inst (.pclk(pclk), .presetn(presetn),
      .cs_n(link_if.cs_n), .sck(link_if.sck), .sdi(link_if.sdi),
      .sdo_out(link_if.sdo_out), .sdo_oe(link_if.sdo_oe), .sdo(link_if.sdo));
   // bits seen on the wire at each clock rise
   always @(posedge pclk)
   begin
      sck_q <= link_if.sck;
      if (link_if.sck && !sck_q)
         mon <= {mon[14:0], link_if.sdi};
   end
   task close_out;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20)
      begin
         @(posedge pclk);
         n++;
      end
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20)
      begin
         failures++;
         close_out();
      end
   endtask
   task wait_idle;
      int n;
      q = 32'h1;
      for (n = 0; n < 400 && q[STATUS_BUSY_POS] !== 1'b0; n++)
         apb(1'b0, HOST_STATUS_ADDR, 32'h0);
      if (q[STATUS_BUSY_POS] !== 1'b0)
      begin
         failures++;
         close_out();
      end
   endtask
   task send(input logic [15:0] w);
      wait_idle();
      apb(1'b1, HOST_CMD_ADDR, {16'h0, w});
      wait_idle();
      `CHK("wire word", w, mon)
   endtask
   task rd(input logic [6:0] a, input logic [7:0] x, input string n);
      send({1'b1, a, 8'hA5});
      apb(1'b0, HOST_RDATA_ADDR, 32'h0);
      `CHK(n, x, q[7:0])
   endtask
   function automatic logic [11:0] fmt(input logic [11:0] s);
      logic [11:0] r;
      r = s ^ {pf[5], 11'h000};
      if (pf[6])
         r[11:1] = r[11:1] ^ {11{r[0]}};
      return r;
   endfunction
   task outs;
      `CHK("duty", pf[7], dsd)
      `CHK("scramble", pf[6], ose)
      `CHK("signed", pf[5], sfs)
      `CHK("sleep", pf[4], slp)
      `CHK("chan pd", {pf[4] | pf[3], pf[4] | pf[0]}, cpd)
      `CHK("out mode", om, omo)
      @(posedge pclk);
      repeat (NAP_RECOVER_SAMPLES) @(posedge pclk);
      sample_in <= 12'($urandom);
      repeat (2) @(posedge pclk);
      `CHK("sample", fmt(sample_in), sample_out)
   endtask
   initial
   begin
      void'($urandom(82066));
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      wait_idle();
      `CHK("auto reset", 1'b1, q[STATUS_RESET_POS])
      `CHK("reset word", SOFT_RESET_WORD, mon)
      pf = 8'h00;
      om = 8'h00;
      outs();
      $display("test reset done");
      for (i = 0; i < 6; i++)
      begin
         d = (i == 0) ? 8'hFF : 8'($urandom);
         e = (i == 1) ? 8'h00 : 8'($urandom);
         send({1'b0, POWER_AND_FORMAT_CONTROL_ADDR, d});
         send({1'b0, OUTPUT_MODE_CONTROL_ADDR, e});
         pf = d & POWER_FORMAT_MASK;
         om = e;
         rd(POWER_AND_FORMAT_CONTROL_ADDR, pf, "pf reg");
         rd(POWER_AND_FORMAT_CONTROL_ADDR, pf, "pf reread");
         rd(OUTPUT_MODE_CONTROL_ADDR, om, "om reg");
         outs();
      end
      $display("test write read done");
      send({1'b0, SOFT_RESET_CONTROL_ADDR, 8'h7F});
      send({1'b0, 7'h05, 8'($urandom)});
      send({1'b0, 7'h7F, 8'hFF});
      rd(7'h05, 8'h00, "unassigned");
      rd(SOFT_RESET_CONTROL_ADDR, 8'h00, "reset reg");
      outs();
      $display("test dont care done");
      interface_select <= 1'b1;
      send({1'b0, OUTPUT_MODE_CONTROL_ADDR, ~om});
      interface_select <= 1'b0;
      repeat (4) @(posedge pclk);
      outs();
      $display("test select done");
      send({1'b0, SOFT_RESET_CONTROL_ADDR, 8'hFF});
      pf = 8'h00;
      om = 8'h00;
      outs();
      rd(SOFT_RESET_CONTROL_ADDR, 8'h00, "self clear");
      $display("test soft reset done");
      e = 8'h3C;
      apb(1'b1, HOST_CMD_ADDR, {16'h0, 1'b0, OUTPUT_MODE_CONTROL_ADDR, e});
      apb(1'b1, HOST_CMD_ADDR, {16'h0, 1'b0, OUTPUT_MODE_CONTROL_ADDR, 8'hC3});
      wait_idle();
      om = e;
      rd(OUTPUT_MODE_CONTROL_ADDR, om, "busy refuse");
      apb(1'b0, 8'h0C, 32'h0);
      `CHK("unmapped", 32'h0, q)
      `CHK("slverr", 1'b0, pslverr)
      $display("test apb done");
      close_out();
   end
endmodule
